//--- verilog/gdpc_pkg.sv
// shared constants and types of the gate driver protection configuration block
`default_nettype none
package gdpc_pkg;
    localparam int CLK_PERIOD_NS = 10;

    // register port
    localparam int ADDR_W = 4;
    localparam int REG_W = 11;
    localparam logic [ADDR_W-1:0] ADDR_OCP_CTRL = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_AMP_CTRL = 4'h6;
    localparam logic [REG_W-1:0] OCP_CTRL_RESET = 11'h159;
    localparam logic [REG_W-1:0] AMP_CTRL_RESET = 11'h283;
    localparam int AMP_INPUT_SELECT_BIT = 10;
    localparam int LOWSIDE_MEASURE_REF_BIT = 8;

    // retry wait after an overcurrent fault
    localparam int T_RETRY_LONG_MS = 4;
    localparam int T_RETRY_SHORT_US = 50;
    localparam int RETRY_LONG_CYCLES = (T_RETRY_LONG_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RETRY_SHORT_CYCLES = (T_RETRY_SHORT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // dead time
    localparam int DEAD_W = 8;
    localparam int T_DEAD0_NS = 50;
    localparam int T_DEAD1_NS = 100;
    localparam int T_DEAD2_NS = 200;
    localparam int T_DEAD3_NS = 400;

    // overcurrent deglitch
    localparam int DEG_W = 10;
    localparam int T_DEG0_US = 2;
    localparam int T_DEG1_US = 4;
    localparam int T_DEG2_US = 6;
    localparam int T_DEG3_US = 8;

    typedef enum logic [1:0] {
        RESP_LATCH = 2'h0,
        RESP_RETRY = 2'h1,
        RESP_REPORT = 2'h2,
        RESP_IGNORE = 2'h3
    } gdpc_resp_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RETRY = 2'h1,
        ST_LATCH = 2'h2
    } gdpc_state_e;

    typedef struct packed {
        logic retry_time_select;
        logic [1:0] dead_time;
        gdpc_resp_e overcurrent_response;
        logic [1:0] overcurrent_deglitch;
        logic [3:0] drain_source_threshold;
    } gdpc_ocp_cfg_s;

    typedef struct packed {
        logic amp_input_select;
        logic ref_divide;
        logic lowside_measure_ref;
        logic [1:0] amp_gain;
        logic sense_fault_disable;
        logic amp_a_offset_cal;
        logic amp_b_offset_cal;
        logic amp_c_offset_cal;
        logic [1:0] sense_trip_level;
    } gdpc_amp_cfg_s;

    typedef struct packed {
        logic [2:0] high;
        logic [2:0] low;
    } gdpc_gate_s;

    function automatic logic [DEAD_W-1:0] dead_cycles(input logic [1:0] code);
        unique case (code)
            2'h0: dead_cycles = DEAD_W'((T_DEAD0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
            2'h1: dead_cycles = DEAD_W'((T_DEAD1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
            2'h2: dead_cycles = DEAD_W'((T_DEAD2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
            2'h3: dead_cycles = DEAD_W'((T_DEAD3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
        endcase
    endfunction

    function automatic logic [DEG_W-1:0] deglitch_cycles(input logic [1:0] code);
        unique case (code)
            2'h0: deglitch_cycles = DEG_W'((T_DEG0_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
            2'h1: deglitch_cycles = DEG_W'((T_DEG1_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
            2'h2: deglitch_cycles = DEG_W'((T_DEG2_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
            2'h3: deglitch_cycles = DEG_W'((T_DEG3_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
        endcase
    endfunction
endpackage
`default_nettype wire

//--- verilog/gdpc_deglitch.sv
// persistence filter: a level is recognised only after it has held for a set number of cycles
`default_nettype none
module gdpc_deglitch #(
    parameter int CNT_W = 10
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic level,
    input wire logic [CNT_W-1:0] threshold,
    output logic recognized
);
    logic [CNT_W-1:0] cnt_q;

    // counter saturates so a long fault never wraps and drops out
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!level) begin
            cnt_q <= '0;
        end else if (cnt_q < threshold) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            recognized <= 1'b0;
        end else begin
            recognized <= level && (cnt_q >= CNT_W'(threshold - 1'b1));
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_deglitch_drop;
        !level |=> !recognized;
    endproperty
    a_deglitch_drop: assert property (p_deglitch_drop) else $error("recognised without a held level");

    property p_deglitch_time;
        $rose(recognized) |-> $past(cnt_q) >= CNT_W'($past(threshold) - 1'b1);
    endproperty
    a_deglitch_time: assert property (p_deglitch_time) else $error("recognised before the deglitch time");
endmodule
`default_nettype wire

//--- verilog/gdpc_dead_time.sv
// non-overlap insertion between high and low gate drive of each phase
`default_nettype none
module gdpc_dead_time #(
    parameter int PHASES = 3,
    parameter int CNT_W = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [PHASES-1:0] hi_req,
    input wire logic [PHASES-1:0] lo_req,
    input wire logic [CNT_W-1:0] dead_cyc,
    input wire logic kill,
    output logic [PHASES-1:0] gate_hi,
    output logic [PHASES-1:0] gate_lo
);
    logic [PHASES-1:0][CNT_W-1:0] off_cnt_q;
    logic [PHASES-1:0] done;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    for (genvar i = 0; i < PHASES; i++) begin : g_phase
        // both requested is treated as neither, so a bad input never shoots through
        assign done[i] = off_cnt_q[i] >= CNT_W'(dead_cyc - 1'b1);

        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                off_cnt_q[i] <= '0;
            end else if (gate_hi[i] || gate_lo[i]) begin
                off_cnt_q[i] <= '0;
            end else if (!done[i]) begin
                off_cnt_q[i] <= off_cnt_q[i] + 1'b1;
            end
        end

        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                gate_hi[i] <= 1'b0;
                gate_lo[i] <= 1'b0;
            end else begin
                gate_hi[i] <= !kill && hi_req[i] && !lo_req[i] && (gate_hi[i] || (!gate_lo[i] && done[i]));
                gate_lo[i] <= !kill && lo_req[i] && !hi_req[i] && (gate_lo[i] || (!gate_hi[i] && done[i]));
            end
        end

        property p_no_overlap;
            !(gate_hi[i] && gate_lo[i]);
        endproperty
        a_no_overlap: assert property (p_no_overlap) else $error("high and low gate on together");

        property p_dead_gap;
            $rose(gate_hi[i]) || $rose(gate_lo[i]) |-> $past(off_cnt_q[i]) >= CNT_W'($past(dead_cyc) - 1'b1);
        endproperty
        a_dead_gap: assert property (p_dead_gap) else $error("gate turned on inside the dead time");

        property p_kill_off;
            kill |=> !gate_hi[i] && !gate_lo[i];
        endproperty
        a_kill_off: assert property (p_kill_off) else $error("gate driven during a fault");
    end
endmodule
`default_nettype wire

//--- verilog/gdpc_top.sv
// overcurrent protection and sense amplifier configuration registers with their fault logic
//
// Contract
// - retry bit picks 4 ms or 50 us wait
// - dead-time code inserts 50/100/200/400 ns gap
// - response 00b gives latched fault until cleared
// - response 01b gives fault clearing after retry
// - response 10b reports only, drivers keep running
// - response 11b neither reports nor acts
// - deglitch code sets 2/4/6/8 us persistence
// - four-bit code selects drain-source trip voltage
// - amp input select forces low-side reference bit
// - reference divide picks full or half reference
// - low-side reference picks measurement pin
// - gain code selects 5/10/20/40 V/V
// - sense disable bit suppresses sense fault
// - calibration bits short amplifier inputs A/B/C
// - sense trip code selects 0.25..1 V
// - amplifier register only on variants with amplifiers
// - protection register sits at address 0x05
// - cycle-wise clear ends retry on PWM input
`default_nettype none
module gdpc_top
    import gdpc_pkg::*;
#(
    parameter bit HAS_SENSE_AMP = 1'b1,
    parameter int RETRY_LONG = gdpc_pkg::RETRY_LONG_CYCLES,
    parameter int RETRY_SHORT = gdpc_pkg::RETRY_SHORT_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [gdpc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [gdpc_pkg::REG_W-1:0] reg_wdata,
    output logic [gdpc_pkg::REG_W-1:0] reg_rdata,
    output logic reg_rvalid,
    input wire gdpc_pkg::gdpc_gate_s pwm_in,
    input wire logic vds_trip_raw,
    input wire logic sense_trip_raw,
    input wire logic cycle_wise_clear,
    input wire logic fault_clear_req,
    output gdpc_pkg::gdpc_gate_s gate_out,
    output gdpc_pkg::gdpc_ocp_cfg_s ocp_cfg,
    output gdpc_pkg::gdpc_amp_cfg_s amp_cfg,
    output logic drain_source_overcurrent,
    output logic sense_resistor_overcurrent,
    output logic fault_active
);
    import gdpc_pkg::*;

    localparam int RETRY_W = $clog2(RETRY_LONG + 1);
    localparam int SYNC_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [5:0] pwm_prev_q;
    gdpc_gate_s pwm_s;
    logic vds_s;
    logic sense_s;
    logic pwm_rise;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {sense_trip_raw, vds_trip_raw, pwm_in};
            sync2_q <= sync1_q;
        end
    end

    assign pwm_s = sync2_q[5:0];
    assign vds_s = sync2_q[6];
    assign sense_s = sync2_q[7];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pwm_prev_q <= '0;
        end else begin
            pwm_prev_q <= pwm_s;
        end
    end

    assign pwm_rise = |(pwm_s & ~pwm_prev_q);

    ////////////////////////////////////////////////////////////////////////////
    // register file

    logic [REG_W-1:0] amp_wdata;

    // selecting the switch node as amplifier input must also move the low-side reference
    always_comb begin
        amp_wdata = reg_wdata;
        if (reg_wdata[AMP_INPUT_SELECT_BIT]) begin
            amp_wdata[LOWSIDE_MEASURE_REF_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ocp_cfg <= OCP_CTRL_RESET;
        end else if (reg_wr_en && reg_addr == ADDR_OCP_CTRL) begin
            ocp_cfg <= reg_wdata;
        end
    end

    // fields steer the analog amplifier stage directly
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            amp_cfg <= AMP_CTRL_RESET;
        end else if (HAS_SENSE_AMP && reg_wr_en && reg_addr == ADDR_AMP_CTRL) begin
            amp_cfg <= amp_wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd_en;
            if (reg_rd_en) begin
                if (reg_addr == ADDR_OCP_CTRL) begin
                    reg_rdata <= ocp_cfg;
                end else if (HAS_SENSE_AMP && reg_addr == ADDR_AMP_CTRL) begin
                    reg_rdata <= amp_cfg;
                end else begin
                    reg_rdata <= '0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // overcurrent detection

    logic vds_rec;
    logic sense_rec;
    logic vds_rec_prev_q;
    logic sense_rec_prev_q;
    logic sense_en;
    logic vds_evt;
    logic sense_evt;
    logic oc_evt;
    logic [DEG_W-1:0] deg_thr;

    assign deg_thr = deglitch_cycles(ocp_cfg.overcurrent_deglitch);

    gdpc_deglitch #(.CNT_W(DEG_W)) u_deg_vds (
        .clock(clock),
        .rst_n(rst_n),
        .level(vds_s),
        .threshold(deg_thr),
        .recognized(vds_rec)
    );

    gdpc_deglitch #(.CNT_W(DEG_W)) u_deg_sense (
        .clock(clock),
        .rst_n(rst_n),
        .level(sense_s),
        .threshold(deg_thr),
        .recognized(sense_rec)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            vds_rec_prev_q <= 1'b0;
            sense_rec_prev_q <= 1'b0;
        end else begin
            vds_rec_prev_q <= vds_rec;
            sense_rec_prev_q <= sense_rec;
        end
    end

    assign sense_en = HAS_SENSE_AMP && !amp_cfg.sense_fault_disable;
    assign vds_evt = vds_rec && !vds_rec_prev_q && ocp_cfg.overcurrent_response != RESP_IGNORE;
    assign sense_evt = sense_en && sense_rec && !sense_rec_prev_q
        && ocp_cfg.overcurrent_response != RESP_IGNORE;
    assign oc_evt = vds_evt || sense_evt;

    ////////////////////////////////////////////////////////////////////////////
    // fault response

    gdpc_state_e state_q;
    gdpc_state_e state_d;
    logic [RETRY_W-1:0] retry_cnt_q;
    logic retry_done;
    logic flag_clear;

    assign retry_done = (cycle_wise_clear && pwm_rise) || retry_cnt_q == '0;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (oc_evt && ocp_cfg.overcurrent_response == RESP_LATCH) begin
                    state_d = ST_LATCH;
                end else if (oc_evt && ocp_cfg.overcurrent_response == RESP_RETRY) begin
                    state_d = ST_RETRY;
                end
            end
            ST_RETRY: begin
                if (retry_done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_LATCH: begin
                // a new latched event in the clear cycle keeps the fault
                if (fault_clear_req && !(oc_evt && ocp_cfg.overcurrent_response == RESP_LATCH)) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // the timer value is taken when the fault starts; a later write does not shorten it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            retry_cnt_q <= '0;
        end else if (state_q != ST_RETRY && state_d == ST_RETRY) begin
            retry_cnt_q <= ocp_cfg.retry_time_select ? RETRY_W'(RETRY_SHORT - 1) : RETRY_W'(RETRY_LONG - 1);
        end else if (state_q == ST_RETRY && retry_cnt_q != '0) begin
            retry_cnt_q <= retry_cnt_q - 1'b1;
        end
    end

    assign flag_clear = fault_clear_req || (state_q == ST_RETRY && state_d == ST_IDLE);

    // status flags: a set in the clear cycle wins
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            drain_source_overcurrent <= 1'b0;
            sense_resistor_overcurrent <= 1'b0;
        end else begin
            drain_source_overcurrent <= vds_evt || (drain_source_overcurrent && !flag_clear);
            sense_resistor_overcurrent <= sense_evt || (sense_resistor_overcurrent && !flag_clear);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fault_active <= 1'b0;
        end else begin
            fault_active <= state_d != ST_IDLE || vds_evt || sense_evt
                || ((drain_source_overcurrent || sense_resistor_overcurrent) && !flag_clear);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // gate drive

    // report-only mode never enters a fault state, so gates keep following pwm
    gdpc_dead_time #(.PHASES(3), .CNT_W(DEAD_W)) u_dead (
        .clock(clock),
        .rst_n(rst_n),
        .hi_req(pwm_s.high),
        .lo_req(pwm_s.low),
        .dead_cyc(dead_cycles(ocp_cfg.dead_time)),
        .kill(state_q != ST_IDLE),
        .gate_hi(gate_out.high),
        .gate_lo(gate_out.low)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_retry_load;
        state_q != ST_RETRY ##1 state_q == ST_RETRY |->
            retry_cnt_q == ($past(ocp_cfg.retry_time_select) ? RETRY_W'(RETRY_SHORT - 1) : RETRY_W'(RETRY_LONG - 1));
    endproperty
    a_retry_load: assert property (p_retry_load) else $error("retry timer loaded with wrong wait");

    property p_latch_hold;
        state_q == ST_LATCH && !fault_clear_req |=> state_q == ST_LATCH;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched fault left without a clear");

    property p_retry_expire;
        state_q == ST_RETRY && retry_cnt_q == '0 |=>
            state_q == ST_IDLE && (!drain_source_overcurrent || $past(vds_evt));
    endproperty
    a_retry_expire: assert property (p_retry_expire) else $error("retrying fault did not clear");

    property p_report_only;
        vds_evt && ocp_cfg.overcurrent_response == RESP_REPORT && state_q == ST_IDLE |=>
            drain_source_overcurrent && state_q == ST_IDLE;
    endproperty
    a_report_only: assert property (p_report_only) else $error("report mode acted or missed the flag");

    property p_ignore;
        ocp_cfg.overcurrent_response == RESP_IGNORE && !fault_active |=> !fault_active;
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignored overcurrent was reported");

    property p_input_forces_ref;
        amp_cfg.amp_input_select |-> amp_cfg.lowside_measure_ref;
    endproperty
    a_input_forces_ref: assert property (p_input_forces_ref) else $error("low-side reference not forced");

    property p_sense_disable;
        amp_cfg.sense_fault_disable && !sense_resistor_overcurrent |=> !sense_resistor_overcurrent;
    endproperty
    a_sense_disable: assert property (p_sense_disable) else $error("disabled sense fault raised");

    property p_amp_absent;
        reg_rd_en && reg_addr != ADDR_OCP_CTRL && (reg_addr != ADDR_AMP_CTRL || !HAS_SENSE_AMP) |=>
            reg_rvalid && reg_rdata == '0;
    endproperty
    a_amp_absent: assert property (p_amp_absent) else $error("absent amplifier register answered");

    property p_ocp_write;
        reg_wr_en && reg_addr == ADDR_OCP_CTRL |=> ocp_cfg == $past(reg_wdata);
    endproperty
    a_ocp_write: assert property (p_ocp_write) else $error("protection register write lost");

    property p_cycle_clear;
        state_q == ST_RETRY && cycle_wise_clear && pwm_rise |=> state_q == ST_IDLE;
    endproperty
    a_cycle_clear: assert property (p_cycle_clear) else $error("pwm input did not clear retry fault");

    property p_fault_gates_low;
        state_q != ST_IDLE |=> gate_out == '0;
    endproperty
    a_fault_gates_low: assert property (p_fault_gates_low) else $error("gates active during fault");
endmodule
`default_nettype wire

//--- tb/gdpc_host_model.sv
// controller-side model driving the parallel register strobe port
`default_nettype none
module gdpc_host_model
    import gdpc_pkg::*;
(
    input wire logic clock,
    output logic wr_en,
    output logic rd_en,
    output logic [gdpc_pkg::ADDR_W-1:0] addr,
    output logic [gdpc_pkg::REG_W-1:0] wdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = '0;
        wdata = '0;
    end

    // one-cycle strobe, launched just after an edge and held over the taking edge
    task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        @(posedge clock);
        #1;
        wr_en = w;
        rd_en = ~w;
        addr = a;
        wdata = d;
        @(posedge clock);
        #1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        // stale data would hide a write taken on the wrong edge
        wdata = ~d;
    endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the protection configuration block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import gdpc_pkg::*;

    logic clock, rst_n, wr_en, rd_en, rvalid, cwc, fclr, vds, sen, dso, sro, fa;
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0] wdata, rdata, w;
    gdpc_gate_s pwm, gate;
    gdpc_ocp_cfg_s ocp;
    gdpc_amp_cfg_s amp;
    logic [REG_W-1:0] exp_q[$];
    int mismatches = 0;
    int samples_checked = 0;

    gdpc_host_model gdpc_host_model_inst (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata));

    // short retry counts keep the run brief
    gdpc_top #(.HAS_SENSE_AMP(1'b1), .RETRY_LONG(300), .RETRY_SHORT(100)) gdpc_top_inst (
        .clock(clock), .rst_n(rst_n), .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .pwm_in(pwm), .vds_trip_raw(vds),
        .sense_trip_raw(sen), .cycle_wise_clear(cwc), .fault_clear_req(fclr), .gate_out(gate),
        .ocp_cfg(ocp), .amp_cfg(amp), .drain_source_overcurrent(dso),
        .sense_resistor_overcurrent(sro), .fault_active(fa));

    task automatic final_report();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_lvl(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rd(input logic [REG_W-1:0] got);
        logic [REG_W-1:0] exp;
        logic hit;
        hit = exp_q.size() > 0;
        exp = hit ? exp_q.pop_front() : ~got;
        samples_checked++;
        if (!hit || got !== exp) begin
            mismatches++;
            $display("Error at %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        gdpc_host_model_inst.access(1'b1, a, d);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] exp);
        exp_q.push_back(exp);
        gdpc_host_model_inst.access(1'b0, a, '0);
    endtask

    // one overcurrent event under a given response code, then clear
    task automatic oc_run(input logic [1:0] mode);
        wr(ADDR_OCP_CTRL, {1'b1, 2'b01, mode, 2'b00, 4'h9});
        step(40);
        chk_lvl(REG_W'(gate.high[0]), 11'h001);
        vds = 1'b1;
        step(230);
        chk_lvl(REG_W'(dso), REG_W'(mode != 2'b11));
        chk_lvl(REG_W'(gate.high[0]), REG_W'(mode[1]));
        vds = 1'b0;
        step(100);
        chk_lvl(REG_W'(fa), REG_W'(!mode[0]));
        fclr = 1'b1;
        step(1);
        fclr = 1'b0;
        step(2);
        chk_lvl(REG_W'(fa), 11'h000);
    endtask

    // read answers are compared mid-cycle, where they are settled
    always @(negedge clock) begin
        if (rvalid === 1'b1) begin
            chk_rd(rdata);
        end
    end

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        repeat (5000) @(posedge clock);
        mismatches++;
        final_report();
    end

    initial begin
        rst_n = 1'b0;
        pwm = '0;
        vds = 1'b0;
        sen = 1'b0;
        cwc = 1'b0;
        fclr = 1'b0;
        w = 11'($urandom(32'hd249));
        step(10);
        rst_n = 1'b1;
        rd(ADDR_OCP_CTRL, OCP_CTRL_RESET);
        rd(ADDR_AMP_CTRL, AMP_CTRL_RESET);
        rd(4'h7 + 4'($urandom_range(8)), 11'h000);
        w = 11'($urandom);
        wr(ADDR_OCP_CTRL, w);
        chk_lvl(ocp, w);
        rd(ADDR_OCP_CTRL, w);
        w = 11'($urandom) | 11'h400;
        wr(ADDR_AMP_CTRL, w);
        rd(ADDR_AMP_CTRL, w | 11'h100);
        wr(ADDR_AMP_CTRL, AMP_CTRL_RESET);
        pwm.high[0] = 1'b1;
        for (int m = 0; m < 4; m++) begin
            oc_run(2'(m));
        end
        // long retry still running, then a pwm edge ends it early
        cwc = 1'b1;
        wr(ADDR_OCP_CTRL, {1'b0, 2'b01, 2'b01, 2'b00, 4'h9});
        vds = 1'b1;
        step(230);
        vds = 1'b0;
        step(100);
        chk_lvl(REG_W'(fa), 11'h001);
        pwm.high[0] = 1'b0;
        step(4);
        pwm.high[0] = 1'b1;
        step(4);
        chk_lvl(REG_W'(fa), 11'h000);
        cwc = 1'b0;
        // a short glitch and a disabled sense fault must both stay silent
        wr(ADDR_OCP_CTRL, 11'h289);
        wr(ADDR_AMP_CTRL, AMP_CTRL_RESET | 11'h020);
        vds = 1'b1;
        sen = 1'b1;
        step(150);
        vds = 1'b0;
        step(80);
        chk_lvl(REG_W'(dso), 11'h000);
        chk_lvl(REG_W'(sro), 11'h000);
        sen = 1'b0;
        wr(ADDR_AMP_CTRL, AMP_CTRL_RESET);
        sen = 1'b1;
        step(230);
        chk_lvl(REG_W'(sro), 11'h001);
        step(5);
        final_report();
    end
endmodule
`default_nettype wire
